// ==== gpio_pin_config_irq_bank.sv ====
// Per-pin configuration and interrupt bank of a 16-pin I/O expander.
// Assumes a serial framer outside that turns host frames into
// one-cycle register reads and writes on the port below.
//
// Contract
// [R1] Direction bit 0 drives the pin as output, 1 makes it input.
// [R2] After reset every pin is an input.
// [R3] Low register: MSB pin 7, LSB pin 0; high: MSB 15, LSB 8.
// [R4] Pull-up bit 1 enables the pin pull-up, 0 disables it.
// [R5] An input interrupts only when its interrupt enable bit is 1.
// [R6] After reset all interrupt enable bits are cleared.
// [R7] A pin configured as output never interrupts.
// [R8] Three-state bit 1 puts the output pin in high impedance.
// [R9] Read-only status bits are set for inputs that interrupted.
// [R10] Rising-edge enable 1 makes the input interrupt on rising edges.
// [R11] Falling-edge enable 1 makes the input interrupt on falling edges.
// [R12] Filter enable registers reset to all ones.
// [R13] Filtered pulses longer than 1075 ns can raise an interrupt.
// [R14] Filtered pulses shorter than 225 ns never raise an interrupt.
// [R15] Filter enable bit 0 turns that pin's filter off.
// [R16] Unfiltered, any input change can raise an interrupt.
// [R17] Reading a state register clears pending interrupts of its pins.
// [R18] Both edge bits 0: either edge; clear on read or return to level.
// [R19] Interrupt line is low while any status bit is set.
// [R20] Host reads status, then state registers, to find and clear.
`timescale 1ns/100ps
`include "gpio_params.svh"
module gpio_pin_config_irq_bank
   import gpio_pkg::*;
#(
   parameter int FILT_CYCLES = `FILT_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port from the serial framer
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Output levels kept by the output level registers
   input wire logic [15:0] out_level,
   // Pins
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe,
   output logic [15:0] pullup_en,
   // Open-drain interrupt line
   output logic irq_n_out,
   output logic irq_n_oe
);
   pin_vec_t pin_direction;
   pin_vec_t pullup_enable;
   pin_vec_t irq_enable;
   pin_vec_t hiz_control;
   pin_vec_t rise_irq_enable;
   pin_vec_t fall_irq_enable;
   pin_vec_t glitch_filter_enable;
   pin_vec_t next_pin_direction;
   pin_vec_t next_pullup_enable;
   pin_vec_t next_irq_enable;
   pin_vec_t next_hiz_control;
   pin_vec_t next_rise_irq_enable;
   pin_vec_t next_fall_irq_enable;
   pin_vec_t next_glitch_filter_enable;
   pin_vec_t filtered;
   pin_vec_t state_rd;
   reg_byte_t next_reg_rdata;
   logic [15:0] next_pin_out;
   logic [15:0] next_pin_oe;
   logic next_irq_n_oe;

   gpio_irq_if irq_bus ();

   // Which half of a register pair an offset names, if any
   function automatic half_sel_t pair_half(input logic [7:0] addr,
      input logic [7:0] low_off);
      half_sel_t h;
      h = HALF_NONE;
      if (addr == low_off)
      begin
         h = HALF_LOW;
      end
      else if (addr == low_off + 8'h01)
      begin
         h = HALF_HIGH;
      end
      return h;
   endfunction : pair_half

   // Replace one byte of a pin vector; low byte is pins 7..0
   function automatic pin_vec_t put_half(input pin_vec_t old,
      input half_sel_t h, input reg_byte_t data);
      pin_vec_t v;
      v = old;
      case (h)
         HALF_LOW: v[7:0] = data; // R3
         HALF_HIGH: v[15:8] = data; // R3
         default: v = old;
      endcase
      return v;
   endfunction : put_half

   // Pick the byte of a pin vector that a read returns
   function automatic reg_byte_t get_half(input pin_vec_t v,
      input half_sel_t h);
      reg_byte_t b;
      case (h)
         HALF_LOW: b = v[7:0];
         HALF_HIGH: b = v[15:8];
         default: b = `READ_UNMAPPED;
      endcase
      return b;
   endfunction : get_half

   // Input filters; bypassed pins see the raw level
   glitch_filter #(
      .WIDTH(16),
      .CYCLES(FILT_CYCLES)
   ) u_filter (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .raw(pin_in),
      .enable(glitch_filter_enable),
      .clean(filtered)
   );

   // Interrupt edge detection and sticky status
   irq_detect u_irq (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bus(irq_bus.irq)
   );

   // Feed the detector
   assign irq_bus.dir_input = pin_direction;
   assign irq_bus.irq_en = irq_enable;
   assign irq_bus.rise_en = rise_irq_enable;
   assign irq_bus.fall_en = fall_irq_enable;
   assign irq_bus.pins = filtered;
   assign irq_bus.state_rd = state_rd;

   // A state read clears only the eight pins of the half it covers
   always_comb
   begin
      state_rd = '0;
      if (reg_rd)
      begin
         case (pair_half(reg_addr, `OFF_PIN_STATE_LOW))
            HALF_LOW: state_rd[7:0] = 8'hff; // R17
            HALF_HIGH: state_rd[15:8] = 8'hff; // R17
            default: state_rd = '0;
         endcase
      end
   end

   // Register writes; status and state offsets ignore writes
   always_comb
   begin
      next_pin_direction = pin_direction;
      next_pullup_enable = pullup_enable;
      next_irq_enable = irq_enable;
      next_hiz_control = hiz_control;
      next_rise_irq_enable = rise_irq_enable;
      next_fall_irq_enable = fall_irq_enable;
      next_glitch_filter_enable = glitch_filter_enable;
      if (reg_wr)
      begin
         next_pin_direction = put_half(pin_direction,
            pair_half(reg_addr, `OFF_PIN_DIRECTION_LOW), reg_wdata);
         next_pullup_enable = put_half(pullup_enable,
            pair_half(reg_addr, `OFF_PULLUP_ENABLE_LOW), reg_wdata);
         next_irq_enable = put_half(irq_enable,
            pair_half(reg_addr, `OFF_IRQ_ENABLE_LOW), reg_wdata);
         next_hiz_control = put_half(hiz_control,
            pair_half(reg_addr, `OFF_HIZ_CONTROL_LOW), reg_wdata);
         next_rise_irq_enable = put_half(rise_irq_enable,
            pair_half(reg_addr, `OFF_RISE_IRQ_ENABLE_LOW), reg_wdata);
         next_fall_irq_enable = put_half(fall_irq_enable,
            pair_half(reg_addr, `OFF_FALL_IRQ_ENABLE_LOW), reg_wdata);
         next_glitch_filter_enable = put_half(glitch_filter_enable,
            pair_half(reg_addr, `OFF_GLITCH_FILTER_ENABLE_LOW),
            reg_wdata); // R15
      end
   end

   // Read data; unmapped offsets answer zero
   always_comb
   begin
      next_reg_rdata = `READ_UNMAPPED;
      if (reg_rd)
      begin
         next_reg_rdata =
            get_half(filtered, pair_half(reg_addr, `OFF_PIN_STATE_LOW))
            | get_half(pin_direction,
               pair_half(reg_addr, `OFF_PIN_DIRECTION_LOW))
            | get_half(pullup_enable,
               pair_half(reg_addr, `OFF_PULLUP_ENABLE_LOW))
            | get_half(irq_enable, pair_half(reg_addr, `OFF_IRQ_ENABLE_LOW))
            | get_half(hiz_control,
               pair_half(reg_addr, `OFF_HIZ_CONTROL_LOW))
            | get_half(irq_bus.status,
               pair_half(reg_addr, `OFF_IRQ_STATUS_LOW)) // R9
            | get_half(rise_irq_enable,
               pair_half(reg_addr, `OFF_RISE_IRQ_ENABLE_LOW))
            | get_half(fall_irq_enable,
               pair_half(reg_addr, `OFF_FALL_IRQ_ENABLE_LOW))
            | get_half(glitch_filter_enable,
               pair_half(reg_addr, `OFF_GLITCH_FILTER_ENABLE_LOW));
      end
   end

   // Pin drivers; an input or three-stated pin is never driven
   always_comb
   begin
      next_pin_out = out_level;
      next_pin_oe = ~pin_direction & ~hiz_control; // R1 R8
      next_irq_n_oe = |irq_bus.status; // R19
   end

   // Register the configuration
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_direction <= {`RST_PIN_DIRECTION, `RST_PIN_DIRECTION}; // R2
         pullup_enable <= {`RST_CLEARED, `RST_CLEARED};
         irq_enable <= {`RST_CLEARED, `RST_CLEARED}; // R6
         hiz_control <= {`RST_CLEARED, `RST_CLEARED};
         rise_irq_enable <= {`RST_CLEARED, `RST_CLEARED};
         fall_irq_enable <= {`RST_CLEARED, `RST_CLEARED};
         glitch_filter_enable <=
            {`RST_GLITCH_FILTER, `RST_GLITCH_FILTER}; // R12
      end
      else
      begin
         pin_direction <= next_pin_direction;
         pullup_enable <= next_pullup_enable;
         irq_enable <= next_irq_enable;
         hiz_control <= next_hiz_control;
         rise_irq_enable <= next_rise_irq_enable;
         fall_irq_enable <= next_fall_irq_enable;
         glitch_filter_enable <= next_glitch_filter_enable;
      end
   end

   // Register every output so the pads see no combinational glitches
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= '0;
         pin_out <= '0;
         pin_oe <= '0;
         pullup_en <= '0;
         irq_n_out <= 1'b0;
         irq_n_oe <= 1'b0;
      end
      else
      begin
         reg_rdata <= next_reg_rdata;
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         pullup_en <= pullup_enable; // R4
         irq_n_out <= 1'b0; // Open drain only ever pulls low
         irq_n_oe <= next_irq_n_oe; // R19
      end
   end
endmodule : gpio_pin_config_irq_bank

// ==== gpio_params.svh ====
// Constants of the pin configuration and interrupt bank.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// Register offsets on the internal register port
`define OFF_PIN_STATE_LOW 8'h00
`define OFF_PIN_STATE_HIGH 8'h01
`define OFF_PIN_DIRECTION_LOW 8'h06
`define OFF_PIN_DIRECTION_HIGH 8'h07
`define OFF_PULLUP_ENABLE_LOW 8'h08
`define OFF_PULLUP_ENABLE_HIGH 8'h09
`define OFF_IRQ_ENABLE_LOW 8'h0a
`define OFF_IRQ_ENABLE_HIGH 8'h0b
`define OFF_HIZ_CONTROL_LOW 8'h0c
`define OFF_HIZ_CONTROL_HIGH 8'h0d
`define OFF_IRQ_STATUS_LOW 8'h0e
`define OFF_IRQ_STATUS_HIGH 8'h0f
`define OFF_RISE_IRQ_ENABLE_LOW 8'h10
`define OFF_RISE_IRQ_ENABLE_HIGH 8'h11
`define OFF_FALL_IRQ_ENABLE_LOW 8'h12
`define OFF_FALL_IRQ_ENABLE_HIGH 8'h13
`define OFF_GLITCH_FILTER_ENABLE_LOW 8'h14
`define OFF_GLITCH_FILTER_ENABLE_HIGH 8'h15

// Reset values of one byte-wide register half, and the read value of unmapped offsets
`define RST_PIN_DIRECTION 8'hff
`define RST_GLITCH_FILTER 8'hff
`define RST_CLEARED 8'h00
`define READ_UNMAPPED 8'h00

// Glitch filter timing
`define CLK_PERIOD_NS 20
`define FILT_REJECT_NS 225
`define FILT_ACCEPT_NS 1075
// Least time rounded up, plus one sample so that a pulse just under the
// reject time can never be seen on enough samples to pass
`define FILT_CYCLES \
   ((`FILT_REJECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)

`endif

// ==== gpio_pkg.sv ====
// Types shared by the pin configuration and interrupt bank.
// Assumes 16 pins split in a low and a high byte.
package gpio_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [15:0] pin_vec_t;
   // Which byte half of a per-pin register pair an access hits
   typedef enum {HALF_NONE, HALF_LOW, HALF_HIGH} half_sel_t;
endpackage : gpio_pkg

// ==== gpio_irq_if.sv ====
// Bundle between the register file and the interrupt detector.
// Assumes one clock domain; both sides on clk_sys.
`timescale 1ns/100ps
interface gpio_irq_if;
   import gpio_pkg::*;
   pin_vec_t dir_input;
   pin_vec_t irq_en;
   pin_vec_t rise_en;
   pin_vec_t fall_en;
   pin_vec_t pins;
   pin_vec_t state_rd;
   pin_vec_t status;
   modport ctrl (output dir_input, irq_en, rise_en, fall_en, pins,
      state_rd, input status);
   modport irq (input dir_input, irq_en, rise_en, fall_en, pins,
      state_rd, output status);
endinterface : gpio_irq_if

// ==== glitch_filter.sv ====
// Per-pin input glitch filter with a per-pin bypass.
// Assumes raw inputs already synchronous to clk_sys.
`timescale 1ns/100ps
`include "gpio_params.svh"
module glitch_filter
   import gpio_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int CYCLES = `FILT_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins
   input wire logic [WIDTH-1:0] raw,
   input wire logic [WIDTH-1:0] enable,
   output logic [WIDTH-1:0] clean
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic loaded;

   // First sample after reset loads the pin level, so a pin idling high
   // shows no false rising edge once reset is released
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         loaded <= 1'b0;
      end
      else
      begin
         loaded <= 1'b1;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_pin
         logic [CW-1:0] count;
         logic [CW-1:0] next_count;
         logic next_clean;

         // A new level must hold for CYCLES samples before it passes
         always_comb
         begin
            next_count = '0;
            next_clean = clean[i];
            if (!enable[i] || !loaded)
            begin
               next_clean = raw[i]; // R15 R16
            end
            else if (raw[i] != clean[i])
            begin
               if (count == LAST)
               begin
                  next_clean = raw[i]; // R13
               end
               else
               begin
                  next_count = count + 1'b1; // R14
               end
            end
         end

         // Register the filter state
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               count <= '0;
               clean[i] <= 1'b0;
            end
            else
            begin
               count <= next_count;
               clean[i] <= next_clean;
            end
         end
      end
   endgenerate
endmodule : glitch_filter

// ==== irq_detect.sv ====
// Edge detection and sticky interrupt status for every input pin.
// Assumes filtered pins and one-cycle state-read strobes per pin.
`timescale 1ns/100ps
module irq_detect
   import gpio_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Configuration, pins and status
   gpio_irq_if.irq bus
);
   pin_vec_t prev;
   pin_vec_t last_read;
   pin_vec_t status;
   logic primed;
   logic warm;
   pin_vec_t next_prev;
   pin_vec_t next_last_read;
   pin_vec_t next_status;
   pin_vec_t rise_ev;
   pin_vec_t fall_ev;
   pin_vec_t sel_ev;
   pin_vec_t revert;
   pin_vec_t allowed;

   // Pick edges by mode, set wins over every clear in the same cycle
   always_comb
   begin
      rise_ev = bus.pins & ~prev;
      fall_ev = ~bus.pins & prev;
      sel_ev = (bus.rise_en & ~bus.fall_en & rise_ev) // R10
         | (bus.fall_en & ~bus.rise_en & fall_ev) // R11
         | (~(bus.rise_en ^ bus.fall_en) & (rise_ev | fall_ev)); // R18
      allowed = bus.dir_input & bus.irq_en; // R5 R7
      // Either-edge mode with both edge bits 0 also clears when the pin is back at its read level
      revert = ~bus.rise_en & ~bus.fall_en & ~(bus.pins ^ last_read); // R18
      next_status = (sel_ev & allowed & {16{primed}})
         | (status & ~(bus.state_rd | revert)); // R9 R17
      next_status = next_status & allowed; // R7
      next_prev = bus.pins;
      next_last_read = last_read;
      for (int i = 0; i < 16; i++)
      begin
         if (bus.state_rd[i] || !primed)
         begin
            next_last_read[i] = bus.pins[i];
         end
      end
   end

   // Register detector state; no edges are judged in the first two
   // cycles, while the filter still loads the pin levels after reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev <= '0;
         last_read <= '0;
         status <= '0;
         primed <= 1'b0;
         warm <= 1'b0;
      end
      else
      begin
         prev <= next_prev;
         last_read <= next_last_read;
         status <= next_status;
         warm <= 1'b1;
         primed <= warm;
      end
   end

   assign bus.status = status;
endmodule : irq_detect

// ==== host_model.sv ====
// Host model: strobed register reads and writes.
// Assumes the bank clock; drives just after rising edges.
`timescale 1ns/100ps
module host_model
   import gpio_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle port shows inverted values so stale data is never reused
   initial
   begin
      reg_addr = 8'hff;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input reg_byte_t a, input reg_byte_t d);
      @(posedge clk_sys) #2;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk_sys) #2;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // Data is taken one cycle after the strobe edge
   task automatic rd(input reg_byte_t a, output reg_byte_t d);
      @(posedge clk_sys) #2;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys) #2;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
   // Both state halves are read after the status to clear
   task automatic clear_state();
      reg_byte_t d;
      rd(8'h00, d);
      rd(8'h01, d);
   endtask : clear_state
endmodule : host_model

// ==== gpio_pin_config_irq_bank_properties.sv ====
// Checker of the pin bank, watching its top ports only.
// Assumes one clock domain and the chosen register offsets.
`timescale 1ns/100ps
module gpio_bank_checker
#(
   parameter int FILT_CYCLES = 13
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Pins and interrupt line
   input wire logic [15:0] out_level,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] pullup_en,
   input wire logic irq_n_out,
   input wire logic irq_n_oe
);
   logic [7:0] quiet;
   logic [7:0] next_quiet;
   logic [15:0] prev_pin;
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Cycles since pins moved; saturates so it never wraps
   always_comb
   begin
      next_quiet = (quiet == 8'hff) ? quiet : quiet + 8'h01;
      if (pin_in != prev_pin)
         next_quiet = 8'h00;
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         quiet <= 8'h00;
         prev_pin <= 16'h0000;
      end
      else
      begin
         quiet <= next_quiet;
         prev_pin <= pin_in;
      end
   end
   sequence wr_to(logic [7:0] a, logic [7:0] d);
      reg_wr && reg_addr == a && reg_wdata == d;
   endsequence
   property oe_off(logic [7:0] a, logic [7:0] d, logic [15:0] m);
      wr_to(a, d) |=> ##1 (pin_oe & m) == 16'h0000;
   endproperty
   chk_dir_low_off: assert property (oe_off(8'h06, 8'hff, 16'h00ff))
      else $error("low pins driven after input select");
   chk_dir_high_off: assert property (oe_off(8'h07, 8'hff, 16'hff00))
      else $error("high pins driven after input select");
   chk_hiz_low_off: assert property (oe_off(8'h0c, 8'hff, 16'h00ff))
      else $error("low pins driven in three-state");
   chk_pullup_follow: assert property (reg_wr && reg_addr == 8'h08 |=>
      ##1 pullup_en[7:0] == $past(reg_wdata, 2))
      else $error("pull-up enables differ from write");
   chk_reset_inputs: assert property ($rose(rst_n) |->
      pin_oe == 16'h0000 && pullup_en == 16'h0000)
      else $error("pins not inputs after reset");
   chk_irq_low_level: assert property (irq_n_out == 1'b0)
      else $error("interrupt line drives high");
   chk_irq_cause: assert property ($rose(irq_n_oe) |->
      quiet <= FILT_CYCLES + 4)
      else $error("interrupt without a recent edge");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data without a read");
endmodule : gpio_bank_checker
bind gpio_pin_config_irq_bank gpio_bank_checker
   #(.FILT_CYCLES(FILT_CYCLES)) u_gpio_bank_checker (.clk_sys(clk_sys),
   .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .out_level(out_level),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .pullup_en(pullup_en), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// ==== gpio_pin_config_irq_bank_tb.sv ====
// Self-checking bench of the pin bank with a host model on its port.
// Assumes 50 MHz and a shortened glitch filter count.
`timescale 1ns/100ps
module gpio_pin_config_irq_bank_tb;
   import gpio_pkg::*;
   localparam int FC = 4;
   typedef struct {reg_byte_t a; reg_byte_t rst; logic ro;} row_t;
   logic clk_sys, rst_n, reg_wr, reg_rd, irq_n_out, irq_n_oe;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   pin_vec_t out_level, pin_in, pin_out, pin_oe, pullup_en;
   int num_errors = 0;
   int samples_checked = 0;
   reg_byte_t d, d2;
   // Offset, reset value, read-only; last row is unmapped
   row_t rows [17] = '{'{8'h06, 8'hff, 0}, '{8'h07, 8'hff, 0},
      '{8'h08, 8'h00, 0}, '{8'h09, 8'h00, 0}, '{8'h0a, 8'h00, 0},
      '{8'h0b, 8'h00, 0}, '{8'h0c, 8'h00, 0}, '{8'h0d, 8'h00, 0},
      '{8'h0e, 8'h00, 1}, '{8'h0f, 8'h00, 1}, '{8'h10, 8'h00, 0},
      '{8'h11, 8'h00, 0}, '{8'h12, 8'h00, 0}, '{8'h13, 8'h00, 0},
      '{8'h14, 8'hff, 0}, '{8'h15, 8'hff, 0}, '{8'h30, 8'h00, 1}};
   gpio_pin_config_irq_bank #(.FILT_CYCLES(FC)) u_gpio_pin_config_irq_bank
      (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .out_level(out_level), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
   host_model u_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic check(input string n, input pin_vec_t s, input pin_vec_t e);
      samples_checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic reset_dut();
      @(posedge clk_sys) #2;
      rst_n = 1'b0;
      repeat (6) @(posedge clk_sys);
      #2;
      rst_n = 1'b1;
   endtask : reset_dut
   // Move pins, wait past the filter, then look at line and status
   task automatic step(input pin_vec_t p, input pin_vec_t st);
      @(posedge clk_sys) #2;
      pin_in = p;
      repeat (FC + 6) @(posedge clk_sys);
      #2;
      check("irq_line", {15'h0, irq_n_oe}, {15'h0, st != 16'h0});
      check("irq_drive", {15'h0, irq_n_out}, 16'h0000);
      u_host_model.rd(8'h0e, d);
      u_host_model.rd(8'h0f, d2);
      check("status", {d2, d}, st);
   endtask : step
   task automatic summarize();
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   initial
   begin
      rst_n = 1'b0;
      out_level = 16'h3c5a;
      pin_in = 16'h0000;
      reset_dut();
      // Reset value, write, read back; read-only places keep reset value
      foreach (rows[i])
      begin
         u_host_model.rd(rows[i].a, d);
         check("reset", {8'h0, d}, {8'h0, rows[i].rst});
         u_host_model.wr(rows[i].a, 8'ha5);
         u_host_model.rd(rows[i].a, d);
         d2 = rows[i].ro ? rows[i].rst : 8'ha5;
         check("readback", {8'h0, d}, {8'h0, d2});
      end
      // Reset after every register was written
      reset_dut();
      check("oe_reset", pin_oe, 16'h0000);
      foreach (rows[i])
      begin
         u_host_model.rd(rows[i].a, d);
         check("rereset", {8'h0, d}, {8'h0, rows[i].rst});
      end
      // Outputs, three-state and pull-ups with bit mapping
      u_host_model.wr(8'h06, 8'h00);
      u_host_model.wr(8'h0c, 8'h0f);
      u_host_model.wr(8'h07, 8'h7f);
      u_host_model.wr(8'h09, 8'h81);
      repeat (2) @(posedge clk_sys);
      #2;
      check("pin_oe", pin_oe, 16'h80f0);
      check("pullup", pullup_en, 16'h8100);
      check("pin_out", pin_out, out_level);
      // Three-state, then input select, switch every driver off
      u_host_model.wr(8'h0c, 8'hff);
      u_host_model.wr(8'h06, 8'hff);
      u_host_model.wr(8'h07, 8'hff);
      repeat (2) @(posedge clk_sys);
      #2;
      check("oe_off", pin_oe, 16'h0000);
      // Interrupt setup: pin5 output, pin4 masked, pin6 filtered
      reset_dut();
      u_host_model.wr(8'h06, 8'hdf);
      u_host_model.wr(8'h0a, 8'h6b);
      u_host_model.wr(8'h0b, 8'h01);
      u_host_model.wr(8'h10, 8'h78);
      u_host_model.wr(8'h11, 8'h01);
      u_host_model.wr(8'h12, 8'h01);
      u_host_model.wr(8'h14, 8'h40);
      u_host_model.wr(8'h15, 8'h00);
      step(16'h0010, 16'h0000);
      step(16'h0030, 16'h0000);
      step(16'h0038, 16'h0008);
      u_host_model.clear_state();
      step(16'h0038, 16'h0000);
      step(16'h0039, 16'h0000);
      step(16'h0038, 16'h0001);
      u_host_model.clear_state();
      step(16'h0030, 16'h0000);
      step(16'h0032, 16'h0002);
      step(16'h0030, 16'h0000);
      step(16'h0130, 16'h0100);
      u_host_model.clear_state();
      // Short pulse on the filtered pin, then a held level
      @(posedge clk_sys) #2;
      pin_in = 16'h0170;
      repeat (FC - 2) @(posedge clk_sys);
      #2;
      pin_in = 16'h0130;
      step(16'h0130, 16'h0000);
      step(16'h0170, 16'h0040);
      summarize();
   end
endmodule : gpio_pin_config_irq_bank_tb
